// ---- common/mc_polarity_regs.vh ----
`ifndef MC_POLARITY_REGS_VH
`define MC_POLARITY_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_FREE_POLARITY 8'h50
`define OFS_CH0_VALUE 8'h54
`define OFS_CH1_VALUE 8'h58
`define OFS_CH2_VALUE 8'h5c
`define OFS_CH3_VALUE 8'h60

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define POL_W 2
`define POL_ALL_W 8
`define VAL_W 16
`define POL_RESET 8'h00
`define VAL_RESET 16'h0000
`define MODE_W 3
`define MODE_OUTPUT 3'h0
`define MODE_IN_MAX 3'h4
`define MSEL_W 2
`define MSEL_PLAIN 2'h0
`define PROTECTION_LEVEL_W 2
`define PROTECTION_LEVEL_LOCK_HI 2'h3
`define PROTECTION_LEVEL_LOCK_MID 2'h2

// ****************************************************************
// Polarity encodings
// ****************************************************************
`define POL_RISE 2'h0
`define POL_FALL 2'h1
`define POL_BOTH 2'h3

// ****************************************************************
// Bus answers
// ****************************************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ADDR_W 8

`endif

// ---- rtl/channel_value_slot.v ----
`timescale 1ns/1ps
`include "mc_polarity_regs.vh"

// One channel's value field, its shadow and its compare result.
module channel_value_slot #(
  parameter VAL_W = `VAL_W
) (
  input wire clk_i,
  input wire rst_i,
  input wire input_mode_i,
  input wire shadow_en_i,
  input wire update_event_i,
  input wire capture_i,
  input wire [VAL_W-1:0] counter_i,
  input wire wr_i,
  input wire [VAL_W-1:0] wdata_i,
  output reg [VAL_W-1:0] value_o,
  output reg [VAL_W-1:0] active_o,
  output reg match_o
);

  // ****************************************************************
  // Value and active compare registers
  // ****************************************************************
  // Capture wins over a write; writes are dropped in input mode anyway.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      value_o <= `VAL_RESET;
      active_o <= `VAL_RESET;
      match_o <= 1'b0;
    end
    else
    begin
      if (input_mode_i && capture_i)
        value_o <= counter_i;
      else if (!input_mode_i && wr_i)
        value_o <= wdata_i;
      // Unshadowed writes reach the comparator on the same edge as the value field
      if (!input_mode_i && !shadow_en_i && wr_i)
        active_o <= wdata_i;
      else if (update_event_i && shadow_en_i)
        active_o <= value_o;
      else if (!shadow_en_i)
        active_o <= value_o;
      match_o <= !input_mode_i && (counter_i == active_o);
    end
  end

endmodule

// ---- rtl/multi_channel_polarity_and_values.v ----
// Behaviour
// - Output mode with plain signal select: code 00 active high, 01 active low.
// - Input code 00: rising edge active, input passed uninverted.
// - Input code 01: falling edge active, input inverted.
// - Input code 11: both edges active, uninverted; code 10 reserved.
// - Polarity writes ignored while protection level is 11 or 10.
// - Polarity register holds four 2-bit fields, channel 0 lowest.
// - Polarity register accepts half-word or word writes.
// - Input mode: value field loads counter at each capture event.
// - Input mode: value field read-only, writes ignored.
// - Output mode: value field compared against counter.
// - Shadow enabled: written value moves to active compare on update event.
// - All five registers reset to zero.
// - Per-channel shadow enable bit buffers writes until update when set.
// - Mode code 000 is output; other defined codes are input.
`timescale 1ns/1ps
`include "mc_polarity_regs.vh"

module multi_channel_polarity_and_values #(
  parameter NCH = 4,
  parameter VAL_W = `VAL_W
) (
  input wire clk_i,
  input wire rst_i,
  // AXI4-Lite slave
  input wire [`ADDR_W-1:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [`ADDR_W-1:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // Timer side
  input wire [VAL_W-1:0] counter_i,
  input wire update_event_i,
  input wire [NCH-1:0] capture_event_i,
  input wire [NCH*`MODE_W-1:0] mode_selection_i,
  input wire [NCH*`MSEL_W-1:0] output_signal_select_i,
  input wire [NCH-1:0] compare_shadow_enable_i,
  input wire [`PROTECTION_LEVEL_W-1:0] protection_level_i,
  input wire [NCH-1:0] channel_in_i,
  input wire [NCH-1:0] ref_out_i,
  output reg [NCH-1:0] channel_out_o,
  output reg [NCH-1:0] channel_in_cond_o,
  output reg [NCH-1:0] active_edge_o,
  output wire [NCH-1:0] compare_match_o,
  output wire [NCH-1:0] input_mode_o,
  output wire [NCH*VAL_W-1:0] active_compare_o
);

  // ****************************************************************
  // Write channel: address and data latched in either order
  // ****************************************************************
  reg aw_held_ff;
  reg w_held_ff;
  reg [`ADDR_W-1:0] aw_addr_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  wire do_write;
  wire [`ADDR_W-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;

  // Ready only while nothing of that channel is held and no answer pends
  assign s_axi_awready_o = !aw_held_ff && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_held_ff && !s_axi_bvalid_o;
  assign wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr_i;
  assign wr_data = w_held_ff ? w_data_ff : s_axi_wdata_i;
  assign wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb_i;
  assign do_write = !s_axi_bvalid_o
    && (aw_held_ff || s_axi_awvalid_i)
    && (w_held_ff || s_axi_wvalid_i);

  // ****************************************************************
  // Write decode
  // ****************************************************************
  reg pol_hit;
  reg [NCH-1:0] val_hit;
  reg wr_ok;
  integer k;

  // Polarity register takes half-word or word; value registers word only
  always @*
  begin
    pol_hit = 1'b0;
    val_hit = {NCH{1'b0}};
    wr_ok = 1'b0;
    case (wr_addr)
      `OFS_FREE_POLARITY:
      begin
        wr_ok = (wr_strb == 4'hf) || (wr_strb == 4'h3) || (wr_strb == 4'hc);
        pol_hit = wr_ok && wr_strb[0];
      end
      `OFS_CH0_VALUE, `OFS_CH1_VALUE, `OFS_CH2_VALUE, `OFS_CH3_VALUE:
      begin
        // Narrow writes are refused rather than half-merged
        wr_ok = (wr_strb == 4'hf);
        for (k = 0; k < NCH; k = k + 1)
          if (wr_addr == `OFS_CH0_VALUE + 8'h04 * k[7:0])
            val_hit[k] = wr_ok;
      end
      default:
      begin
        wr_ok = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Write handshake registers
  // ****************************************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= {`ADDR_W{1'b0}};
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `RESP_OKAY;
    end
    else
    begin
      if (do_write)
      begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else
      begin
        if (s_axi_awvalid_i && s_axi_awready_o)
        begin
          aw_held_ff <= 1'b1;
          aw_addr_ff <= s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o)
        begin
          w_held_ff <= 1'b1;
          w_data_ff <= s_axi_wdata_i;
          w_strb_ff <= s_axi_wstrb_i;
        end
        if (s_axi_bvalid_o && s_axi_bready_i)
          s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Polarity register
  // ****************************************************************
  reg [`POL_ALL_W-1:0] polarity_ff;
  wire protection_level_locked;

  assign protection_level_locked = (protection_level_i == `PROTECTION_LEVEL_LOCK_HI)
    || (protection_level_i == `PROTECTION_LEVEL_LOCK_MID);

  // Upper bits are reserved and never stored, so they read as zero
  always @(posedge clk_i)
  begin
    if (rst_i)
      polarity_ff <= `POL_RESET;
    else if (do_write && pol_hit && !protection_level_locked)
      polarity_ff <= wr_data[`POL_ALL_W-1:0];
  end

  // ****************************************************************
  // Per-channel value slots, polarity and edge logic
  // ****************************************************************
  wire [NCH*VAL_W-1:0] value_all;
  wire [NCH-1:0] nxt_channel_out;
  wire [NCH-1:0] nxt_in_cond;
  wire [NCH-1:0] nxt_active_edge;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : gen_ch
      wire [`MODE_W-1:0] mode;
      wire [`POL_W-1:0] pol;
      wire [`MSEL_W-1:0] msel;
      wire cond;

      assign mode = mode_selection_i[g*`MODE_W +: `MODE_W];
      assign pol = polarity_ff[g*`POL_W +: `POL_W];
      assign msel = output_signal_select_i[g*`MSEL_W +: `MSEL_W];
      // Reserved mode codes above the defined inputs fall back to output
      assign input_mode_o[g] = (mode != `MODE_OUTPUT) && (mode <= `MODE_IN_MAX);
      // Only the falling code inverts the input
      assign cond = (pol == `POL_FALL) ? !channel_in_i[g] : channel_in_i[g];

      channel_value_slot #(
        .VAL_W(VAL_W)
      ) u_slot (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .input_mode_i(input_mode_o[g]),
        .shadow_en_i(compare_shadow_enable_i[g]),
        .update_event_i(update_event_i),
        .capture_i(capture_event_i[g]),
        .counter_i(counter_i),
        .wr_i(do_write && val_hit[g]),
        .wdata_i(wr_data[VAL_W-1:0]),
        .value_o(value_all[g*VAL_W +: VAL_W]),
        .active_o(active_compare_o[g*VAL_W +: VAL_W]),
        .match_o(compare_match_o[g])
      );

      // Reserved output codes and non-plain selects pass the level through
      assign nxt_channel_out[g] = (msel == `MSEL_PLAIN && pol == `POL_FALL)
        ? !ref_out_i[g] : ref_out_i[g];
      assign nxt_in_cond[g] = cond;
      // Inversion makes a falling pin edge a rising conditioned edge
      assign nxt_active_edge[g] = input_mode_o[g] && ((pol == `POL_BOTH)
        ? (cond != channel_in_cond_o[g])
        : ((pol == `POL_RISE || pol == `POL_FALL)
          && cond && !channel_in_cond_o[g]));
    end
  endgenerate

  // One process owns the channel outputs, so no bit has two drivers
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      channel_out_o <= {NCH{1'b0}};
      channel_in_cond_o <= {NCH{1'b0}};
      active_edge_o <= {NCH{1'b0}};
    end
    else
    begin
      channel_out_o <= nxt_channel_out;
      channel_in_cond_o <= nxt_in_cond;
      active_edge_o <= nxt_active_edge;
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  reg [31:0] rd_word;
  reg rd_ok;
  integer j;

  always @*
  begin
    rd_word = 32'h00000000;
    rd_ok = 1'b0;
    if (s_axi_araddr_i == `OFS_FREE_POLARITY)
    begin
      rd_word[`POL_ALL_W-1:0] = polarity_ff;
      rd_ok = 1'b1;
    end
    for (j = 0; j < NCH; j = j + 1)
      if (s_axi_araddr_i == `OFS_CH0_VALUE + 8'h04 * j[7:0])
      begin
        rd_word[VAL_W-1:0] = value_all[j*VAL_W +: VAL_W];
        rd_ok = 1'b1;
      end
  end

  assign s_axi_arready_o = !s_axi_rvalid_o;

  // Read data registered one cycle after the address is taken
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_word;
      s_axi_rresp_o <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end

endmodule

// ---- test/mcp_chk.sv ----
`timescale 1ns/1ps
`include "mc_polarity_regs.vh"

// ****************************************************************
// Bus and channel checks
// ****************************************************************
module mcp_chk #(
  parameter NCH = 4,
  parameter VAL_W = 16
) (
  input logic clk_i,
  input logic rst_i,
  input logic s_axi_awvalid_i,
  input logic s_axi_awready_o,
  input logic s_axi_wvalid_i,
  input logic s_axi_wready_o,
  input logic [1:0] s_axi_bresp_o,
  input logic s_axi_bvalid_o,
  input logic s_axi_bready_i,
  input logic s_axi_arvalid_i,
  input logic s_axi_arready_o,
  input logic [31:0] s_axi_rdata_o,
  input logic s_axi_rvalid_o,
  input logic s_axi_rready_i,
  input logic update_event_i,
  input logic [NCH*`MODE_W-1:0] mode_selection_i,
  input logic [NCH-1:0] compare_shadow_enable_i,
  input logic [NCH-1:0] active_edge_o,
  input logic [NCH-1:0] input_mode_o,
  input logic [NCH*VAL_W-1:0] active_compare_o
);
  // One clock domain; every check rests while reset is held
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_reset_clear:
  assert property ($past(rst_i) |-> !s_axi_bvalid_o && !s_axi_rvalid_o && active_compare_o == '0)
    else $error("state not clear after reset");
  a_write_answer:
  assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |=> s_axi_bvalid_o) else $error("write answer late");
  a_bresp_holds:
  assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped");
  a_busy_blocks:
  assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while answer pending");
  a_read_answer:
  assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_rdata_holds:
  assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer dropped");
  a_mode_decode:
  assert property (input_mode_o[0] == (mode_selection_i[2:0] inside {[3'h1:`MODE_IN_MAX]}))
    else $error("input mode decode wrong");
  a_edge_in_only:
  assert property ((active_edge_o & ~$past(input_mode_o)) == '0)
    else $error("edge pulse outside input mode");
  a_shadow_holds:
  assert property ($past(compare_shadow_enable_i[2]) && !$past(input_mode_o[2])
    && !$past(update_event_i) |-> $stable(active_compare_o[2*VAL_W +: VAL_W]))
    else $error("shadowed compare moved without update");
endmodule

bind multi_channel_polarity_and_values mcp_chk #(.NCH(NCH), .VAL_W(VAL_W)) mcp_chk_inst (.*);

// ---- test/tb.sv ----
`timescale 1ns/1ps
`include "mc_polarity_regs.vh"

// ****************************************************************
// Register and channel scenarios
// ****************************************************************
module tb;
  localparam logic [7:0] POL = `OFS_FREE_POLARITY;
  logic clk_i, rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
  logic s_axi_rready_i, update_event_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_arready_o, s_axi_rvalid_o;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i, output_signal_select_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i, capture_event_i, compare_shadow_enable_i, channel_in_i, ref_out_i;
  logic [3:0] channel_out_o, channel_in_cond_o, active_edge_o, compare_match_o, input_mode_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, protection_level_i;
  logic [15:0] counter_i;
  logic [11:0] mode_selection_i;
  logic [63:0] active_compare_o;
  int n_fail = 0;
  int n_tests = 0;

  multi_channel_polarity_and_values multi_channel_polarity_and_values_inst (.*);

  // Free-running 40 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready is raised only after valid, so the slave must hold its answer meanwhile
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] r);
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= s;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b1;
    @(posedge clk_i);
    s_axi_bready_i <= 1'b0;
    check("bresp", s_axi_bresp_o, r);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b1;
    @(posedge clk_i);
    s_axi_rready_i <= 1'b0;
    check("rdata", s_axi_rdata_o, d);
    check("rresp", s_axi_rresp_o, r);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 5; i++)
      axi_rd(POL + 8'(4 * i), 32'h0, `RESP_OKAY);
    axi_rd(8'h64, 32'h0, `RESP_SLVERR);
  endtask

  task automatic t_polarity;
    axi_wr(POL, 32'h0000_00d9, 4'hf, `RESP_OKAY);
    axi_rd(POL, 32'h0000_00d9, `RESP_OKAY);
    axi_wr(POL, 32'h0000_0027, 4'h3, `RESP_OKAY);
    axi_wr(POL, 32'h0000_0000, 4'hc, `RESP_OKAY);
    axi_rd(POL, 32'h0000_0027, `RESP_OKAY);
    for (int i = 3; i >= 1; i--)
    begin
      protection_level_i <= 2'(i);
      axi_wr(POL, 32'h0000_0000, 4'hf, `RESP_OKAY);
      axi_rd(POL, i > 1 ? 32'h27 : 32'h0, `RESP_OKAY);
    end
    protection_level_i <= 2'h0;
  endtask

  // Codes 00, 01, 11 and reserved 10 on channels 0 to 3, all in input mode
  task automatic t_in_pol;
    logic [3:0] acc;
    axi_wr(POL, 32'h0000_00b4, 4'hf, `RESP_OKAY);
    mode_selection_i <= 12'h249;
    for (int e = 0; e < 2; e++)
    begin
      acc = 4'h0;
      channel_in_i <= e ? 4'h0 : 4'hf;
      repeat (4)
      begin
        @(posedge clk_i);
        acc = acc | active_edge_o;
      end
      check("edges", acc, e ? 4'h6 : 4'h5);
      check("cond", channel_in_cond_o, e ? 4'h2 : 4'hd);
    end
  endtask

  task automatic t_out_pol;
    axi_wr(POL, 32'h0000_00e4, 4'hf, `RESP_OKAY);
    mode_selection_i <= 12'h000;
    ref_out_i <= 4'hf;
    for (int s = 0; s < 2; s++)
    begin
      output_signal_select_i <= s ? 8'h04 : 8'h00;
      repeat (3) @(posedge clk_i);
      check("out", channel_out_o, s ? 4'hf : 4'hd);
    end
  endtask

  // Capture takes one pulse; software writes must then bounce off the field
  task automatic t_capture;
    mode_selection_i <= 12'h001;
    counter_i <= 16'h1234;
    capture_event_i <= 4'h1;
    @(posedge clk_i);
    capture_event_i <= 4'h0;
    axi_rd(`OFS_CH0_VALUE, 32'h0000_1234, `RESP_OKAY);
    axi_wr(`OFS_CH0_VALUE, 32'h0000_5555, 4'hf, `RESP_OKAY);
    axi_wr(`OFS_CH0_VALUE, 32'h0000_5555, 4'h3, `RESP_SLVERR);
    axi_rd(`OFS_CH0_VALUE, 32'h0000_1234, `RESP_OKAY);
    // Reserved mode code falls back to output
    mode_selection_i <= 12'h005;
    @(posedge clk_i);
    @(posedge clk_i);
    check("mode", input_mode_o[0], 1'b0);
  endtask

  task automatic t_compare;
    mode_selection_i <= 12'h000;
    compare_shadow_enable_i <= 4'h4;
    axi_wr(`OFS_CH1_VALUE, 32'h0000_00aa, 4'hf, `RESP_OKAY);
    check("act1", active_compare_o[31:16], 16'h00aa);
    for (int k = 0; k < 2; k++)
    begin
      counter_i <= 16'h00aa + 16'(k);
      repeat (3) @(posedge clk_i);
      check("match", compare_match_o[1], k == 0);
    end
    axi_wr(`OFS_CH2_VALUE, 32'h0000_0077, 4'hf, `RESP_OKAY);
    check("shadow", active_compare_o[47:32], 16'h0);
    axi_rd(`OFS_CH2_VALUE, 32'h0000_0077, `RESP_OKAY);
    update_event_i <= 1'b1;
    @(posedge clk_i);
    update_event_i <= 1'b0;
    @(posedge clk_i);
    check("update", active_compare_o[47:32], 16'h0077);
  endtask

  task automatic final_report;
    if (n_fail == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    {s_axi_awaddr_i, s_axi_awvalid_i, s_axi_wdata_i, s_axi_wstrb_i, s_axi_wvalid_i,
     s_axi_bready_i, s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i, counter_i,
     update_event_i, capture_event_i, mode_selection_i, output_signal_select_i,
     compare_shadow_enable_i, protection_level_i, channel_in_i, ref_out_i} = '0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_polarity;
    t_in_pol;
    t_out_pol;
    t_capture;
    t_compare;
    final_report;
  end

  // The scenarios need well under two hundred cycles; this cuts a hung handshake short
  initial
  begin
    repeat (4000) @(posedge clk_i);
    n_fail++;
    final_report;
  end
endmodule
